// ---- logic/subclk_pkg.sv ----
// Purpose: shared constants, types and register layout for clock control
// Assumes: 20 MHz system clock, APB with 32-bit data
// Notes: one state equals one system clock cycle
package subclk_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STANDBY = 8'h00;
  localparam logic [7:0] OFF_LOW_POWER = 8'h04;
  localparam logic [7:0] OFF_STOP_HIGH = 8'h08;
  localparam logic [7:0] OFF_STOP_LOW = 8'h0c;
  localparam logic [7:0] OFF_SERIAL_TIMER = 8'h10;
  localparam logic [7:0] OFF_MODE_STATUS = 8'h14;

  // reset values
  localparam logic [7:0] RST_STANDBY = 8'h00;
  localparam logic [7:0] RST_LOW_POWER = 8'h00;
  localparam logic [7:0] RST_STOP_HIGH = 8'h00;
  localparam logic [7:0] RST_STOP_LOW = 8'h00;
  localparam logic [7:0] RST_SERIAL_TIMER = 8'h00;

  // standby control fields
  localparam int SBY_SOFT_STANDBY_BIT = 7;
  localparam int SBY_WAIT_LSB = 4;
  localparam int SBY_DIV_LSB = 0;
  // low power control fields
  localparam int LPW_DIRECT_BIT = 7;
  localparam int LPW_LOW_SPEED_BIT = 6;
  localparam int LPW_NOISE_SEL_BIT = 5;
  localparam int LPW_SUB_ENABLE_BIT = 4;
  // serial timer control field
  localparam int STC_FLASH_SEL_BIT = 3;

  // wake wait counts in states
  localparam int WAIT_CODE0 = 8192;
  localparam int WAIT_CODE1 = 16384;
  localparam int WAIT_CODE2 = 32768;
  localparam int WAIT_CODE3 = 65536;
  localparam int WAIT_CODE4 = 131072;
  localparam int WAIT_CODE5 = 262144;
  localparam int WAIT_CODE7 = 16;
  localparam int WAIT_W = 19;

  // noise sampler divide ratios
  localparam int SAMPLE_DIV_SLOW = 32;
  localparam int SAMPLE_DIV_FAST = 4;

  // peripheral enable positions
  localparam int NUM_PERIPH = 16;
  localparam int P_TIMER_A = 0;
  localparam int P_TIMER_B = 1;
  localparam int P_WATCHDOG_A = 2;
  localparam int P_WATCHDOG_B = 3;
  localparam logic [15:0] SUB_PERIPH_MASK = 16'h000f;
  localparam logic [15:0] WATCH_PERIPH_MASK = 16'h0008;

  typedef enum logic [7:0] {
    ST_ACTIVE    = 8'h01,
    ST_SLEEP     = 8'h02,
    ST_SUBACTIVE = 8'h04,
    ST_SUBSLEEP  = 8'h08,
    ST_WATCH     = 8'h10,
    ST_SWSTANDBY = 8'h20,
    ST_WAKE_WAIT = 8'h40,
    ST_HWSTANDBY = 8'h80
  } power_state_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic clock_gen_run;
    logic periph_reset;
    logic sys_clk_from_sub;
  } clock_gates_t;

endpackage

// ---- logic/subclock_noise_sampler.sv ----
// Purpose: samples the subclock pin on a divided clock to reject glitches
// Assumes: pin input synchronous to clk
// Notes: output changes only after two equal samples in a row
`timescale 1ns/1ps
module subclock_noise_sampler
  import subclk_pkg::*;
#(
  parameter int DIV_SLOW = SAMPLE_DIV_SLOW,
  parameter int DIV_FAST = SAMPLE_DIV_FAST
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic fast_rate,
  input wire logic pin_in,
  output logic filtered
);

  logic [5:0] div_q;
  logic tick;
  logic sample_q;

  // divided sampling enable, rate from the noise select bit
  assign tick = fast_rate ? (div_q[1:0] == 2'(DIV_FAST - 1))
                          : (div_q[4:0] == 5'(DIV_SLOW - 1));

  // divider only counts while sampling is allowed
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      div_q <= 6'h00;
    end else begin
      div_q <= tick ? 6'h00 : div_q + 6'h01;
    end
  end

  // two equal samples move the filtered level
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_q <= 1'b0;
      filtered <= 1'b0;
    end else if (run && tick) begin
      sample_q <= pin_in;
      if (sample_q == pin_in) begin
        filtered <= pin_in;
      end
    end
  end

endmodule

// ---- logic/subclock_power_mode_control.sv ----
// Purpose: system clock choice and power-down mode sequencing
// Assumes: APB slave, 20 MHz clk, sleep_exec and wake_irq are pulses
// Notes: slower rates are one-cycle enables, never gated clocks
`timescale 1ns/1ps
module subclock_power_mode_control
  import subclk_pkg::*;
#(
  parameter int WAIT0 = WAIT_CODE0,
  parameter int WAIT1 = WAIT_CODE1,
  parameter int WAIT2 = WAIT_CODE2,
  parameter int WAIT3 = WAIT_CODE3,
  parameter int WAIT4 = WAIT_CODE4,
  parameter int WAIT5 = WAIT_CODE5,
  parameter int WAIT7 = WAIT_CODE7
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic hw_standby,
  input wire logic subclock_in_pin,
  output clock_gates_t gates,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic subclock_filtered,
  output logic [7:0] mode_status
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] standby_control_reg_q;
  logic [7:0] low_power_control_reg_q;
  logic [7:0] module_stop_high_reg_q;
  logic [7:0] module_stop_low_reg_q;
  logic [7:0] serial_timer_ctrl_reg_q;
  power_state_t state_q, state_d;
  logic [WAIT_W-1:0] wait_q;
  logic [4:0] div_q;
  logic sub_prev_q;
  logic sub_tick;
  logic sub_mode;
  logic sampler_run;
  logic filtered_raw;
  logic wr_en;
  logic rd_en;
  logic power_reg;
  logic mapped;
  logic soft_standby_select;
  logic [2:0] wake_wait_select;
  logic [2:0] bus_clock_divider_select;
  logic direct_transfer;
  logic low_speed_on;
  logic noise_sample_select;
  logic subclock_input_enable;
  logic flash_reg_select;
  logic [31:0] rdata_d;
  logic [15:0] stop_mask;
  clock_gates_t gates_d;
  logic [NUM_PERIPH-1:0] periph_d;

  ////////////////////////////////////////////////////////////////////////
  // decoding functions

  // cycles of wait for a wait select code
  function automatic logic [WAIT_W-1:0] wait_cycles(input logic [2:0] sel);
    logic [WAIT_W-1:0] n;
    n = WAIT_W'(WAIT5);
    unique case (sel)
      3'h0: n = WAIT_W'(WAIT0);
      3'h1: n = WAIT_W'(WAIT1);
      3'h2: n = WAIT_W'(WAIT2);
      3'h3: n = WAIT_W'(WAIT3);
      3'h4: n = WAIT_W'(WAIT4);
      3'h5: n = WAIT_W'(WAIT5);
      3'h6: n = WAIT_W'(WAIT5); // reserved, longest wait
      3'h7: n = WAIT_W'(WAIT7);
    endcase
    return n;
  endfunction

  // low bits of the divider that must be ones for a cpu enable
  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    logic [4:0] m;
    m = 5'h00;
    unique case (sel)
      3'h0: m = 5'h00;
      3'h1: m = 5'h01;
      3'h2: m = 5'h03;
      3'h3: m = 5'h07;
      3'h4: m = 5'h0f;
      3'h5: m = 5'h1f;
      3'h6: m = 5'h00; // banned code, runs at full speed
      3'h7: m = 5'h00;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register fields

  assign soft_standby_select = standby_control_reg_q[SBY_SOFT_STANDBY_BIT];
  assign wake_wait_select = standby_control_reg_q[SBY_WAIT_LSB+:3];
  assign bus_clock_divider_select = standby_control_reg_q[SBY_DIV_LSB+:3];
  assign direct_transfer = low_power_control_reg_q[LPW_DIRECT_BIT];
  assign low_speed_on = low_power_control_reg_q[LPW_LOW_SPEED_BIT];
  assign noise_sample_select = low_power_control_reg_q[LPW_NOISE_SEL_BIT];
  assign subclock_input_enable = low_power_control_reg_q[LPW_SUB_ENABLE_BIT];
  assign flash_reg_select = serial_timer_ctrl_reg_q[STC_FLASH_SEL_BIT];
  assign stop_mask = {module_stop_high_reg_q, module_stop_low_reg_q};

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state per access

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;
  // power registers hidden while flash select is set
  assign power_reg = (paddr == OFF_STANDBY) || (paddr == OFF_LOW_POWER) ||
                     (paddr == OFF_STOP_HIGH) || (paddr == OFF_STOP_LOW);
  assign mapped = (power_reg && !flash_reg_select) ||
                  (paddr == OFF_SERIAL_TIMER) || (paddr == OFF_MODE_STATUS);

  // read data mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (mapped) begin
      unique case (paddr)
        OFF_STANDBY: rdata_d = {24'h000000, standby_control_reg_q};
        OFF_LOW_POWER: rdata_d = {24'h000000, low_power_control_reg_q};
        OFF_STOP_HIGH: rdata_d = {24'h000000, module_stop_high_reg_q};
        OFF_STOP_LOW: rdata_d = {24'h000000, module_stop_low_reg_q};
        OFF_SERIAL_TIMER: rdata_d = {24'h000000, serial_timer_ctrl_reg_q};
        OFF_MODE_STATUS: rdata_d = {24'h000000, state_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // handshake, read data and error answer
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (rd_en) begin
        prdata <= rdata_d;
      end
    end
  end

  // register writes; hardware standby clears them like reset
  always_ff @(posedge clk) begin
    if (reset || hw_standby) begin
      standby_control_reg_q <= RST_STANDBY;
      low_power_control_reg_q <= RST_LOW_POWER;
      module_stop_high_reg_q <= RST_STOP_HIGH;
      module_stop_low_reg_q <= RST_STOP_LOW;
      serial_timer_ctrl_reg_q <= RST_SERIAL_TIMER;
    end else if (wr_en && mapped) begin
      unique case (paddr)
        OFF_STANDBY: standby_control_reg_q <= pwdata[7:0];
        OFF_LOW_POWER: low_power_control_reg_q <= pwdata[7:0];
        OFF_STOP_HIGH: module_stop_high_reg_q <= pwdata[7:0];
        OFF_STOP_LOW: module_stop_low_reg_q <= pwdata[7:0];
        OFF_SERIAL_TIMER: serial_timer_ctrl_reg_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // subclock input and noise sampler

  assign sub_mode = (state_q == ST_SUBACTIVE) || (state_q == ST_SUBSLEEP) ||
                    (state_q == ST_WATCH);
  // sampler idles in sub modes and while input is disabled
  assign sampler_run = subclock_input_enable && !sub_mode &&
                       (state_q != ST_SWSTANDBY) &&
                       (state_q != ST_HWSTANDBY);

  subclock_noise_sampler u_sampler (
    .clk(clk),
    .reset(reset),
    .run(sampler_run),
    .fast_rate(noise_sample_select),
    .pin_in(subclock_in_pin),
    .filtered(filtered_raw)
  );

  // rising subclock edge used as the sub system clock tick
  always_ff @(posedge clk) begin
    if (reset) begin
      sub_prev_q <= 1'b0;
    end else begin
      sub_prev_q <= subclock_in_pin; // raw level, enabling is no edge
    end
  end
  assign sub_tick = subclock_in_pin && subclock_input_enable &&
                    !sub_prev_q && sub_mode;

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (sleep_exec) begin
          if (!soft_standby_select) begin
            state_d = ST_SLEEP;
          end else if (!low_speed_on) begin
            state_d = ST_SWSTANDBY;
          end else if (direct_transfer) begin
            state_d = ST_SUBACTIVE;
          end else begin
            state_d = ST_WATCH;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_irq) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_SUBACTIVE: begin
        if (sleep_exec) begin
          if (!soft_standby_select) begin
            state_d = ST_SUBSLEEP;
          end else if (low_speed_on) begin
            state_d = ST_WATCH;
          end else begin
            state_d = ST_WAKE_WAIT;
          end
        end
      end
      ST_SUBSLEEP: begin
        if (wake_irq) begin
          state_d = ST_SUBACTIVE;
        end
      end
      ST_WATCH: begin
        if (wake_irq) begin
          state_d = low_speed_on ? ST_SUBACTIVE : ST_WAKE_WAIT;
        end
      end
      ST_SWSTANDBY: begin
        if (wake_irq) begin
          state_d = ST_WAKE_WAIT;
        end
      end
      ST_WAKE_WAIT: begin
        if (wait_q == '0) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_HWSTANDBY: begin
        state_d = ST_ACTIVE;
      end
      default: state_d = ST_ACTIVE;
    endcase
    if (hw_standby) begin
      state_d = ST_HWSTANDBY;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // oscillation settling counter, loaded on entry to the wait
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= '0;
    end else if (state_d == ST_WAKE_WAIT && state_q != ST_WAKE_WAIT) begin
      wait_q <= wait_cycles(wake_wait_select) - WAIT_W'(1);
    end else if (state_q == ST_WAKE_WAIT && wait_q != '0) begin
      wait_q <= wait_q - WAIT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // medium speed divider and clock enables

  // free running divider for the medium speed cpu rate
  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= 5'h00;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // gate and enable values per mode
  always_comb begin
    gates_d = '0;
    periph_d = '0;
    unique case (state_q)
      ST_ACTIVE: begin
        gates_d.clock_gen_run = 1'b1;
        gates_d.cpu_clk_en = ((div_q & div_mask(bus_clock_divider_select))
                              == div_mask(bus_clock_divider_select));
        periph_d = '1;
      end
      ST_SLEEP: begin
        gates_d.clock_gen_run = 1'b1;
        periph_d = '1;
      end
      ST_SUBACTIVE: begin
        gates_d.sys_clk_from_sub = subclock_input_enable;
        gates_d.cpu_clk_en = sub_tick;
        periph_d = SUB_PERIPH_MASK & {NUM_PERIPH{sub_tick}};
      end
      ST_SUBSLEEP: begin
        gates_d.sys_clk_from_sub = subclock_input_enable;
        periph_d = SUB_PERIPH_MASK & {NUM_PERIPH{sub_tick}};
      end
      ST_WATCH: begin
        gates_d.sys_clk_from_sub = subclock_input_enable;
        periph_d = WATCH_PERIPH_MASK & {NUM_PERIPH{sub_tick}};
      end
      ST_SWSTANDBY: begin
        gates_d.clock_gen_run = 1'b0;
      end
      ST_WAKE_WAIT: begin
        gates_d.clock_gen_run = 1'b1;
      end
      ST_HWSTANDBY: begin
        gates_d.periph_reset = 1'b1;
      end
      default: gates_d = '0;
    endcase
    // module stop applies in every mode
    periph_d = periph_d & ~stop_mask;
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      gates <= '0;
      periph_clk_en <= '0;
      subclock_filtered <= 1'b0;
      mode_status <= ST_ACTIVE;
    end else begin
      gates <= gates_d;
      periph_clk_en <= periph_d;
      subclock_filtered <= filtered_raw;
      mode_status <= state_d;
    end
  end

endmodule

// ---- verification/subclock_source.sv ----
// Purpose: stand-in for the outside 32.768 kHz subclock source
// Assumes: period scaled down to whole clk cycles
// Notes: held low while the source is off
`timescale 1ns/1ps
module subclock_source #(
  parameter int HALF = 120
) (
  input wire logic clk,
  input wire logic run,
  output logic pin
);
  int cnt;
  initial pin = 1'b0;
  // square wave of two half periods, still while off
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- verification/subclock_power_mode_control_chk.sv ----
// Purpose: port checks for clock and power mode control
// Assumes: bound to the top module, sync reset
// Notes: mode checks allow gates a few cycles to settle
`timescale 1ns/1ps
module subclock_power_mode_control_chk
  import subclk_pkg::*;
#(
  parameter int WAIT_MAX = WAIT_CODE5 // longest wake wait in cycles
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sleep_exec,
  input wire logic hw_standby,
  input wire clock_gates_t gates,
  input wire logic [NUM_PERIPH-1:0] periph_clk_en,
  input wire logic subclock_filtered,
  input wire logic [7:0] mode_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [19:0] wait_q;
  // cycles spent in the wake wait
  always_ff @(posedge clk) begin
    if (reset || mode_status != 8'h40) begin
      wait_q <= 20'h0;
    end else begin
      wait_q <= wait_q + 20'h1;
    end
  end
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  sequence s_active_sleep;
    mode_status == 8'h01 && $past(mode_status) == 8'h01 && sleep_exec
      && !hw_standby;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ready_wait: assert property ($rose(penable) && psel |-> s_answer)
    else $error("pready not after one wait state");
  a_err_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_sleep_take: assert property (s_active_sleep |=>
    mode_status inside {8'h02, 8'h04, 8'h10, 8'h20})
    else $error("sleep request not taken");
  a_hw_reset: assert property (hw_standby [*3] |-> mode_status == 8'h80
    && periph_clk_en == '0 && !gates.clock_gen_run)
    else $error("hardware standby outputs wrong");
  a_sw_stop: assert property ((mode_status == 8'h20) [*3] |->
    !gates.clock_gen_run && periph_clk_en == '0 && !gates.cpu_clk_en)
    else $error("software standby still clocking");
  a_sleep_halt: assert property ((mode_status == 8'h02) [*3] |->
    !gates.cpu_clk_en && gates.clock_gen_run)
    else $error("sleep gates wrong");
  a_sub_mask: assert property ((mode_status inside {8'h04, 8'h08}) [*3]
    |-> (periph_clk_en & ~SUB_PERIPH_MASK) == '0)
    else $error("sub mode peripheral enable leak");
  a_watch_mask: assert property ((mode_status == 8'h10) [*3] |->
    (periph_clk_en & ~WATCH_PERIPH_MASK) == '0 && !gates.cpu_clk_en)
    else $error("watch mode enable leak");
  a_main_fast: assert property ((mode_status == 8'h01) [*3] |->
    !gates.sys_clk_from_sub && gates.clock_gen_run)
    else $error("active mode not on main clock");
  a_sub_hold: assert property ((mode_status inside
    {8'h04, 8'h08, 8'h10}) [*4] |-> $stable(subclock_filtered))
    else $error("subclock sampled in sub mode");
  a_wait_bound: assert property (mode_status == 8'h40 |-> wait_q < WAIT_MAX)
    else $error("wake wait too long");
endmodule
bind subclock_power_mode_control subclock_power_mode_control_chk #(
  .WAIT_MAX((WAIT0 > WAIT5) ? ((WAIT0 > WAIT7) ? WAIT0 : WAIT7)
                            : ((WAIT5 > WAIT7) ? WAIT5 : WAIT7))
) u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sleep_exec(sleep_exec), .hw_standby(hw_standby), .gates(gates),
  .periph_clk_en(periph_clk_en), .subclock_filtered(subclock_filtered),
  .mode_status(mode_status)
);

// ---- verification/test_subclock_power_mode_control.sv ----
// Purpose: self-checking bench for clock and power mode control
// Assumes: short wake waits but codes 0 and 7, subclock from the source model
// Notes: register traffic over APB, one wait state
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module test_subclock_power_mode_control import subclk_pkg::*;;
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic sleep_exec, wake_irq, hw_standby, pin, filt, sub_run;
  logic [7:0] paddr, mode_status, v;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] pen, m;
  clock_gates_t gates;
  int err_total, tests_run, n;
  int wt[8] = '{8192, 9, 10, 11, 12, 13, 13, 16};
  subclock_power_mode_control #(.WAIT1(9), .WAIT2(10),
    .WAIT3(11), .WAIT4(12), .WAIT5(13)
  ) u_subclock_power_mode_control (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .hw_standby(hw_standby),
    .subclock_in_pin(pin), .gates(gates), .periph_clk_en(pen),
    .subclock_filtered(filt), .mode_status(mode_status)
  );
  subclock_source u_subclock_source (.clk(clk), .run(sub_run), .pin(pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 16) begin
      err_total++;
      close_out();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic e;
    apb(1'b1, a, {24'h0, d}, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic xe);
    logic e;
    apb(1'b0, a, 32'h0, e);
    `CHK(r, {24'h0, x})
    `CHK(e, xe)
  endtask
  // one-cycle sleep or wake pulse, returns at the taking edge
  task automatic kick(input bit s);
    if (s) begin
      sleep_exec <= 1'b1;
    end else begin
      wake_irq <= 1'b1;
    end
    @(posedge clk);
    sleep_exec <= 1'b0;
    wake_irq <= 1'b0;
  endtask
  task automatic wait_mode(input logic [7:0] x);
    int i;
    i = 0;
    while (mode_status !== x && i < 400) begin
      @(posedge clk);
      i++;
    end
    `CHK(mode_status, x)
    if (i >= 400) begin
      close_out();
    end
  endtask
  task automatic count_cpu(input int k);
    n = 0;
    repeat (k) begin
      @(posedge clk);
      n += (gates.cpu_clk_en === 1'b1);
    end
  endtask
  function automatic int div_pulses(input int code, input int cyc);
    return (code >= 1 && code <= 5) ? cyc >> code : cyc;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_exec, wake_irq, hw_standby, sub_run} = '0;
    err_total = 0;
    tests_run = 0;
    n = $urandom(32'hb57322f0);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset values, status and an unmapped word
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 8'h00, 1'b0);
    rd(8'h14, 8'h01, 1'b0);
    rd(8'h18, 8'h00, 1'b1);
    `CHK(pen, 16'hffff)
    // random storage and module stop masks
    repeat (4) begin
      v = 8'($urandom);
      m = 16'($urandom);
      wr(8'h04, v);
      rd(8'h04, v, 1'b0);
      wr(8'h08, m[15:8]);
      wr(8'h0c, m[7:0]);
      repeat (2) @(posedge clk);
      `CHK(pen, ~m)
    end
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    // power registers hidden while flash select set
    wr(8'h10, 8'h08);
    rd(8'h00, 8'h00, 1'b1);
    wr(8'h00, 8'h05);
    wr(8'h10, 8'h00);
    rd(8'h00, 8'h00, 1'b0);
    // every divider code
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c));
      count_cpu(64);
      `CHK(n, div_pulses(c, 64))
    end
    wr(8'h00, 8'h00);
    kick(1'b1);
    wait_mode(8'h02);
    kick(1'b0);
    wait_mode(8'h01);
    // software standby and every wake wait code
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'h80 | 8'(c << 4));
      kick(1'b1);
      wait_mode(8'h20);
      kick(1'b0);
      n = 0;
      for (int i = 0; i < 9000 && mode_status !== 8'h01; i++) begin
        @(posedge clk);
        n += (mode_status === 8'h40);
      end
      if (mode_status !== 8'h01) begin
        err_total++;
        close_out();
      end
      `CHK(n, wt[c])
      rd(8'h00, 8'h80 | 8'(c << 4), 1'b0);
    end
    // subactive with the input disabled, then enabled
    sub_run <= 1'b1;
    wr(8'h04, 8'hc0);
    kick(1'b1);
    wait_mode(8'h04);
    count_cpu(960);
    `CHK(n, 0)
    wr(8'h04, 8'hd0);
    count_cpu(960);
    `CHK(n, 4)
    `CHK(gates.sys_clk_from_sub, 1'b1)
    wr(8'h00, 8'h00);
    kick(1'b1);
    wait_mode(8'h08);
    kick(1'b0);
    wait_mode(8'h04);
    wr(8'h00, 8'hf0);
    kick(1'b1);
    wait_mode(8'h10);
    kick(1'b0);
    wait_mode(8'h04);
    wr(8'h04, 8'h90);
    kick(1'b1);
    wait_mode(8'h40);
    wait_mode(8'h01);
    // noise filter at both sample rates
    for (int c = 0; c < 2; c++) begin
      wr(8'h04, (c == 1) ? 8'h30 : 8'h10);
      v[0] = pin;
      for (int i = 0; i < 300 && pin === v[0]; i++) @(posedge clk);
      if (pin === v[0]) begin
        err_total++;
        close_out();
      end
      repeat (110) @(posedge clk);
      `CHK(filt, pin)
    end
    sub_run <= 1'b0;
    // hardware standby clears registers and peripheral enables, sets peripheral reset
    wr(8'h00, 8'h5d);
    hw_standby <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(mode_status, 8'h80)
    `CHK(pen, 16'h0000)
    `CHK(gates.periph_reset, 1'b1)
    hw_standby <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h00, 8'h00, 1'b0);
    close_out();
  end
endmodule
